// ---- rtl/hbd_pkg.sv ----
// Purpose: Constants and types for the headset and button detect block.
// Assumes: 10 MHz system clock; register reached by its documented port.
// Notes: Times are in microseconds; cycle counts derive from them.
// Behaviour
// - Both detect interrupts are driven active high.
// - Headset insert or removal gives a 1.75 ms interrupt pulse.
// - Two-bit headset debounce: 16, 32, 64, 128 ms with 2-16 ms ticks.
// - Headset flag stays set while the headset stays connected.
// - Button interrupt lasts while held plus the release debounce and one tick.
// - Button interrupt rises one debounce duration plus 0.5 ms after press.
// - Two-bit button debounce: none, 8, 16, 32 ms with 1-4 ms ticks.
// - Button flag sets with the button interrupt, 0.5 ms after a debounced press.
// - Button flag clears only on a read made after release.
// - Headset detection works only while its enable bit is set.
// - Two bits route the headset interrupt to output a, b, or both.
// - Headset status bit updates on insertion or removal.
// - Button status bit updates on a detected press.
package hbd_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_US = 1000;
    localparam int unsigned HS_PULSE_US = 1750;
    localparam int unsigned BTN_DELAY_US = 500;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned HS_PULSE_CYC = HS_PULSE_US * (CLK_HZ / 1000) / MS_US;
    localparam int unsigned BTN_DELAY_CYC = BTN_DELAY_US * (CLK_HZ / 1000) / MS_US;
    localparam int unsigned TICKS_PER_DEB = 8;
    localparam logic [7:0] REG_ADDR = 8'h22;
    localparam int unsigned BIT_HS_EN = 15;
    localparam int unsigned BIT_HS_STAT = 12;
    localparam int unsigned BIT_BTN_STAT = 11;
    localparam int unsigned BIT_HS_DEB_HI = 10;
    localparam int unsigned BIT_HS_DEB_LO = 9;
    localparam int unsigned BIT_ROUTE_B = 4;
    localparam int unsigned BIT_ROUTE_A = 3;
    localparam int unsigned BIT_BTN_DEB_HI = 1;
    localparam int unsigned BIT_BTN_DEB_LO = 0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] WR_MASK = 16'h861B;

    typedef struct packed {
        logic hs_en;
        logic [1:0] hs_deb;
        logic route_b;
        logic route_a;
        logic [1:0] btn_deb;
    } hbd_ctrl_s;
endpackage : hbd_pkg

// ---- rtl/hbd_detect.sv ----
// Purpose: Headset insertion and button press debounce with interrupts.
// Assumes: Jack sense pins are asynchronous and pass two flip-flops.
// Notes: Button interrupt rides output a; headset routing selects a/b.
`timescale 1ns/100ps
module hbd_detect (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic headset_sense_in,
    input wire logic button_sense_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic event_output_a_out,
    output logic event_output_b_out
);
    logic hs_s1, hs_s2, bt_s1, bt_s2;
    logic [15:0] rise;
    hbd_pkg::hbd_ctrl_s ctrl, next_ctrl;
    logic hs_stat, next_hs_stat, bt_stat, next_bt_stat;
    logic bt_flag, next_bt_flag;
    logic [3:0] hs_cnt, next_hs_cnt, bt_cnt, next_bt_cnt;
    logic [15:0] hs_pulse, next_hs_pulse;
    logic [15:0] bt_dly, next_bt_dly;
    logic bt_irq, next_bt_irq;
    logic hs_tick, bt_tick, sel;
    logic [15:0] rd_val, next_rd;

    // Tick index into the millisecond divider chain.
    function automatic logic pick(input logic [15:0] r, input int unsigned i);
        return r[i];
    endfunction : pick

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            {hs_s1, hs_s2, bt_s1, bt_s2} <= 4'h0;
        end else begin
            hs_s1 <= headset_sense_in;
            hs_s2 <= hs_s1;
            bt_s1 <= button_sense_in;
            bt_s2 <= bt_s1;
        end
    end

    // single base divider
    // The lower part counts cycles per millisecond; upper bits give ticks.
    logic [13:0] ms_cnt, next_ms_cnt;
    logic [4:0] ms_div, next_ms_div;
    always_comb begin
        next_ms_cnt = ms_cnt + 14'h0001;
        next_ms_div = ms_div;
        if (ms_cnt == 14'(hbd_pkg::CYC_PER_MS - 1)) begin
            next_ms_cnt = 14'h0000;
            next_ms_div = ms_div + 5'h01;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ms_cnt <= 14'h0000;
            ms_div <= 5'h00;
        end else begin
            ms_cnt <= next_ms_cnt;
            ms_div <= next_ms_div;
        end
    end
    // Bit i rising: 1 ms tick at i=0 (counting from wrap of ms_cnt).
    always_comb begin
        rise = 16'h0000;
        rise[0] = (ms_cnt == 14'(hbd_pkg::CYC_PER_MS - 1));
        for (int i = 1; i < 5; i++) begin
            // Chaining keeps every select one bit wide inside the loop.
            rise[i] = rise[i-1] && ms_div[i-1];
        end
    end

    assign hs_tick = pick(rise, 32'(ctrl.hs_deb) + 1);
    assign bt_tick = (ctrl.btn_deb == 2'h0) ? 1'b1 :
                     pick(rise, 32'(ctrl.btn_deb) - 1);
    assign sel = (reg_addr_in == hbd_pkg::REG_ADDR);

    always_comb begin
        next_ctrl = ctrl;
        next_hs_stat = hs_stat;
        next_hs_cnt = hs_cnt;
        next_hs_pulse = (hs_pulse != 16'h0000) ? hs_pulse - 16'h0001 : hs_pulse;
        next_bt_stat = bt_stat;
        next_bt_cnt = bt_cnt;
        next_bt_flag = bt_flag;
        next_bt_dly = (bt_dly > 16'h0001) ? bt_dly - 16'h0001 : 16'h0000;
        next_bt_irq = bt_irq;
        if (reg_wr_in && sel) begin
            next_ctrl.hs_en = reg_wdata_in[hbd_pkg::BIT_HS_EN];
            next_ctrl.hs_deb = reg_wdata_in[hbd_pkg::BIT_HS_DEB_HI:
                                            hbd_pkg::BIT_HS_DEB_LO];
            next_ctrl.route_b = reg_wdata_in[hbd_pkg::BIT_ROUTE_B];
            next_ctrl.route_a = reg_wdata_in[hbd_pkg::BIT_ROUTE_A];
            next_ctrl.btn_deb = reg_wdata_in[hbd_pkg::BIT_BTN_DEB_HI:
                                             hbd_pkg::BIT_BTN_DEB_LO];
        end
        if (!ctrl.hs_en) begin
            next_hs_cnt = 4'h0;
            next_hs_stat = 1'b0;
            next_hs_pulse = 16'h0000;
        end else if (hs_s2 == hs_stat) begin
            next_hs_cnt = 4'h0;
        end else if (hs_tick) begin
            if (hs_cnt == 4'(hbd_pkg::TICKS_PER_DEB - 1)) begin
                next_hs_stat = hs_s2;
                next_hs_cnt = 4'h0;
                next_hs_pulse = 16'(hbd_pkg::HS_PULSE_CYC);
            end else begin
                next_hs_cnt = hs_cnt + 4'h1;
            end
        end
        if (bt_s2 == bt_stat) begin
            next_bt_cnt = 4'h0;
        end else if (bt_tick) begin
            if (ctrl.btn_deb == 2'h0 ||
                bt_cnt == 4'(hbd_pkg::TICKS_PER_DEB - 1)) begin
                next_bt_stat = bt_s2;
                next_bt_cnt = 4'h0;
                if (bt_s2) begin
                    next_bt_dly = 16'(hbd_pkg::BTN_DELAY_CYC);
                end
            end else begin
                next_bt_cnt = bt_cnt + 4'h1;
            end
        end
        if (reg_rd_in && sel && !bt_stat) begin
            next_bt_flag = 1'b0;
        end
        if (bt_dly == 16'h0001) begin
            next_bt_flag = 1'b1;
            next_bt_irq = 1'b1;
        end
        // low after release debounce plus a tick
        if (bt_irq && !bt_stat && bt_tick && bt_dly == 16'h0000) begin
            next_bt_irq = 1'b0;
        end
        next_rd = 16'h0000;
        next_rd[hbd_pkg::BIT_HS_EN] = ctrl.hs_en;
        next_rd[hbd_pkg::BIT_HS_STAT] = hs_stat;
        next_rd[hbd_pkg::BIT_BTN_STAT] = bt_flag;
        next_rd[hbd_pkg::BIT_HS_DEB_HI:hbd_pkg::BIT_HS_DEB_LO] = ctrl.hs_deb;
        next_rd[hbd_pkg::BIT_ROUTE_B] = ctrl.route_b;
        next_rd[hbd_pkg::BIT_ROUTE_A] = ctrl.route_a;
        next_rd[hbd_pkg::BIT_BTN_DEB_HI:hbd_pkg::BIT_BTN_DEB_LO] = ctrl.btn_deb;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl <= '0;
            hs_stat <= 1'b0;
            hs_cnt <= 4'h0;
            hs_pulse <= 16'h0000;
            bt_stat <= 1'b0;
            bt_cnt <= 4'h0;
            bt_flag <= 1'b0;
            bt_dly <= 16'h0000;
            bt_irq <= 1'b0;
            rd_val <= hbd_pkg::REG_RESET;
            event_output_a_out <= 1'b0;
            event_output_b_out <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            hs_stat <= next_hs_stat;
            hs_cnt <= next_hs_cnt;
            hs_pulse <= next_hs_pulse;
            bt_stat <= next_bt_stat;
            bt_cnt <= next_bt_cnt;
            bt_flag <= next_bt_flag;
            bt_dly <= next_bt_dly;
            bt_irq <= next_bt_irq;
            rd_val <= next_rd;
            event_output_a_out <= (ctrl.route_a && hs_pulse != 16'h0000)
                                  || bt_irq;
            event_output_b_out <= ctrl.route_b && hs_pulse != 16'h0000;
        end
    end
    assign reg_rdata_out = rd_val;

    hs_pulse_len_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(hs_pulse != 16'h0000) |-> (hs_pulse != 16'h0000) [*8])
        else $error("headset pulse too short");
    hs_enable_gate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !ctrl.hs_en |=> hs_pulse == 16'h0000)
        else $error("headset event while disabled");
    bt_flag_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        bt_flag && bt_stat |=> bt_flag)
        else $error("button flag cleared while held");
    bt_flag_set_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        bt_dly == 16'h0001 |=> bt_flag && bt_irq)
        else $error("button flag not set");
    route_b_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !ctrl.route_b |=> !event_output_b_out)
        else $error("output b driven without route");
    hs_stable_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $changed(hs_stat) && $past(ctrl.hs_en) |-> $past(hs_cnt) ==
        4'(hbd_pkg::TICKS_PER_DEB - 1))
        else $error("headset accepted early");
    bt_irq_held_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        bt_irq && bt_stat |=> bt_irq)
        else $error("button irq dropped while held");
    hs_stat_track_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(hs_stat) |-> hs_pulse == 16'(hbd_pkg::HS_PULSE_CYC))
        else $error("status change without pulse");
    hs_insert_c: cover property (@(posedge sys_clk_in) $rose(hs_stat));
    hs_remove_c: cover property (@(posedge sys_clk_in) $fell(hs_stat));
    bt_press_c: cover property (@(posedge sys_clk_in) $rose(bt_irq));
    bt_clear_c: cover property (@(posedge sys_clk_in) $fell(bt_flag));
endmodule : hbd_detect

// ---- verif/hbd_jack_model.sv ----
// Purpose: Behavioural headset jack with a microphone push button.
// Assumes: Contacts are ideal; the bench decides plug and press timing.
// Notes: The button contact closes only while a plug sits in the jack.
`timescale 1ns/100ps
module hbd_jack_model (
    input wire logic plug_in,
    input wire logic press_in,
    output logic headset_sense_out,
    output logic button_sense_out
);
    assign headset_sense_out = plug_in;
    assign button_sense_out = plug_in & press_in;
endmodule : hbd_jack_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the headset and button detect block.
// Assumes: The jack model drives the sense pins; this bench is the host.
// Notes: Headset debounce needs 160000 cycles, so only the button is timed.
`timescale 1ns/100ps
module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic plug = 1'b0;
    logic press = 1'b0;
    logic headset_sense;
    logic button_sense;
    logic [15:0] rdata;
    logic ev_a;
    logic ev_b;
    logic [15:0] w;
    int n_mismatch = 0;
    int checks = 0;

    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    hbd_jack_model i_jack (
        .plug_in(plug),
        .press_in(press),
        .headset_sense_out(headset_sense),
        .button_sense_out(button_sense)
    );

    hbd_detect i_dut (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .headset_sense_in(headset_sense),
        .button_sense_in(button_sense),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(rdata),
        .event_output_a_out(ev_a),
        .event_output_b_out(ev_b)
    );

    // Inputs always change the same 10 ns after a rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #10;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // One strobe cycle, then two edges so the register image catches up.
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [15:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = wr;
        reg_rd_in = ~wr;
        tick(1);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        tick(2);
    endtask : access

    task automatic wait_a(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && ev_a !== lvl; i++) begin
            tick(1);
        end
        check({15'h0000, ev_a}, {15'h0000, lvl});
        if (ev_a !== lvl) begin
            end_of_test();
        end
    endtask : wait_a

    function automatic logic [15:0] exp_reg(input logic [15:0] d,
        input logic btn);
        exp_reg = d & hbd_pkg::WR_MASK;
        exp_reg[hbd_pkg::BIT_BTN_STAT] = btn;
    endfunction : exp_reg

    initial begin
        void'($urandom(92182));
        tick(6);
        rst_n_in = 1'b1;
        tick(1);
        check(rdata, hbd_pkg::REG_RESET);
        check({14'h0000, ev_b, ev_a}, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            w = 16'($urandom());
            access(1'b1, hbd_pkg::REG_ADDR, w);
            check(rdata, exp_reg(w, 1'b0));
            access(1'b1, hbd_pkg::REG_ADDR ^ 8'h01, ~w);
            check(rdata, exp_reg(w, 1'b0));
        end
        // Headset routed to b only: the button must still appear on a.
        w = 16'h8010;
        access(1'b1, hbd_pkg::REG_ADDR, w);
        plug = 1'b1;
        press = 1'b1;
        tick(hbd_pkg::BTN_DELAY_CYC - 100);
        check({15'h0000, ev_a}, 16'h0000);
        wait_a(1'b1, 300);
        tick(2);
        check(rdata, exp_reg(w, 1'b1));
        check({15'h0000, ev_b}, 16'h0000);
        access(1'b0, hbd_pkg::REG_ADDR, 16'h0000);
        tick(1000);
        check(rdata, exp_reg(w, 1'b1));
        check({15'h0000, ev_a}, 16'h0001);
        press = 1'b0;
        wait_a(1'b0, 25000);
        check(rdata, exp_reg(w, 1'b1));
        access(1'b0, hbd_pkg::REG_ADDR, 16'h0000);
        check(rdata, exp_reg(w, 1'b0));
        // A press shorter than the 8 ms button debounce must leave no trace.
        w = 16'h0001;
        access(1'b1, hbd_pkg::REG_ADDR, w);
        press = 1'b1;
        tick(int'(10000 + $urandom() % 50000));
        check({15'h0000, ev_a}, 16'h0000);
        press = 1'b0;
        tick(2000);
        check({15'h0000, ev_a}, 16'h0000);
        check(rdata, exp_reg(w, 1'b0));
        end_of_test();
    end
endmodule : testbench
